// [common/scp_regs.svh]
// register indices, field positions, reset values and masks of the pin block
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
`define SCP_ADDR_W       18
`define SCP_IDX_CARD     16'hFE0A
`define SCP_IDX_EXT      16'hFE0B
`define SCP_IDX_AUXDIR   16'hFE0C
`define SCP_IDX_MODE     16'hFE0E
`define SCP_CARD_RST     7
`define SCP_CARD_DATA    5
`define SCP_CARD_DIR     4
`define SCP_CARD_AUX8    3
`define SCP_CARD_AUX4    2
`define SCP_CARD_LVL     1
`define SCP_CARD_OFF     0
`define SCP_EXT_DATA     5
`define SCP_EXT_DIR      4
`define SCP_EXT_LVL      1
`define SCP_EXT_OFF      0
`define SCP_AUX8_DIR     3
`define SCP_AUX4_DIR     2
`define SCP_MODE_BYPASS  0
`define SCP_MODE_AUTO    1
`define SCP_MODE_ISYNC   2
`define SCP_MODE_ESYNC   3
`define SCP_CARD_RESET   8'h31
`define SCP_EXT_RESET    8'h00
`define SCP_AUXDIR_RESET 8'h0C
`define SCP_MODE_RESET   8'h00
`define SCP_CARD_MASK    8'hBF
`define SCP_EXT_MASK     8'h33
`define SCP_AUXDIR_MASK  8'h0C
`define SCP_MODE_MASK    8'h0F
`define SCP_RESP_OKAY    2'h0
`define SCP_RESP_SLVERR  2'h2
`endif

// [common/scp_pkg.sv]
// types shared by the pin control block
package scp_pkg;
  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP    = 2'b10
  } scp_wstate_type;
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CARD = 3'h1,
    SEL_EXT  = 3'h2,
    SEL_AUX  = 3'h3,
    SEL_MODE = 3'h4
  } scp_sel_type;
  typedef logic [31:0] scp_word_type;
endpackage : scp_pkg

// [hw/scp_pin_sync.sv]
// two-stage pin synchroniser with capture register
`timescale 1ns/100ps
`default_nettype none
module scp_pin_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pinAsync,
  input  wire logic captureEn,
  output var  logic pinLevel,
  output var  logic captured
);
  import scp_pkg::*;
  logic stage1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      pinLevel <= 1'b0;
    end else begin
      stage1 <= pinAsync;
      pinLevel <= stage1;
    end
  end

  // sample on clock rise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      captured <= 1'b0;
    end else if (captureEn) begin
      captured <= pinLevel;
    end
  end
endmodule : scp_pin_sync
`default_nettype wire

// [hw/scp_pin_control.sv]
// smart card pin control registers and pin drivers behind AXI4-Lite
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "scp_regs.svh"
module scp_pin_control (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [17:0]         s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  input  wire scp_pkg::scp_word_type s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output var  logic [1:0]          s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  input  wire logic [17:0]         s_axi_araddr,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output var  scp_pkg::scp_word_type s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  input  wire logic                etuClk,
  input  wire logic                seqRstRelease,
  input  wire logic                uartTxData,
  input  wire logic                uartTxEn,
  input  wire logic                extUartTxData,
  input  wire logic                extUartTxEn,
  output var  logic                cardRst,
  output var  logic                cardClk,
  input  wire logic                cardDataIn,
  output var  logic                cardDataOut,
  output var  logic                cardDataOeN,
  input  wire logic                aux4In,
  output var  logic                aux4Out,
  output var  logic                aux4OeN,
  input  wire logic                aux8In,
  output var  logic                aux8Out,
  output var  logic                aux8OeN,
  input  wire logic                extDataIn,
  output var  logic                extDataOut,
  output var  logic                extDataOeN,
  output var  logic                extClk
);
  import scp_pkg::*;

  logic [7:0]     cardCtl;
  logic [7:0]     extCtl;
  logic [7:0]     auxDir;
  logic [7:0]     modeReg;
  scp_wstate_type wrState;
  logic           awHeld;
  logic           wHeld;
  logic [17:0]    wrAddr;
  logic [7:0]     wrData;
  logic           wrLane;
  logic           commit;
  scp_sel_type    wrSel;
  scp_sel_type    rdSel;
  logic [7:0]     rdByte;
  logic           cardClkPrev;
  logic           extClkPrev;
  logic [3:0]     pinRaw;
  logic [3:0]     capEn;
  logic [3:0]     syncVal;
  logic [3:0]     capVal;
  logic           bypass;
  logic           iSync;
  logic           eSync;
  logic           autoSeq;
  logic           direct;
  logic           extDirect;
  logic           next_cardRst;
  logic           next_cardClk;
  logic           next_extClk;
  logic           etuLevel;
  logic [7:0]     cardRead;
  logic [7:0]     extRead;

  function automatic scp_sel_type decodeSel(input logic [17:0] a);
    scp_sel_type s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[17:2])
        `SCP_IDX_CARD:   s = SEL_CARD;
        `SCP_IDX_EXT:    s = SEL_EXT;
        `SCP_IDX_AUXDIR: s = SEL_AUX;
        `SCP_IDX_MODE:   s = SEL_MODE;
        default:         s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decodeSel

  assign bypass    = modeReg[`SCP_MODE_BYPASS];
  assign autoSeq   = modeReg[`SCP_MODE_AUTO];
  assign iSync     = modeReg[`SCP_MODE_ISYNC];
  assign eSync     = modeReg[`SCP_MODE_ESYNC];
  assign direct    = bypass | iSync;
  assign extDirect = bypass | eSync;
  assign commit    = (wrState == WS_COLLECT) && awHeld && wHeld;
  assign wrSel     = decodeSel(wrAddr);
  assign rdSel     = decodeSel(s_axi_araddr);

  // write channel collection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wrAddr <= 18'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      wrAddr <= s_axi_awaddr;
    end else if (commit) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wHeld <= 1'b0;
      wrData <= 8'h00;
      wrLane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wrData <= s_axi_wdata[7:0];
      wrLane <= s_axi_wstrb[0];
    end else if (commit) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= (wrState == WS_COLLECT) && !awHeld &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= (wrState == WS_COLLECT) && !wHeld &&
                      !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrState <= WS_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCP_RESP_OKAY;
    end else begin
      case (wrState)
        WS_COLLECT: begin
          if (commit) begin
            wrState <= WS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrSel == SEL_NONE) ? `SCP_RESP_SLVERR
                                               : `SCP_RESP_OKAY;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            wrState <= WS_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wrState <= WS_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cardCtl <= `SCP_CARD_RESET;
    end else if (commit && wrLane && wrSel == SEL_CARD) begin
      cardCtl <= wrData & `SCP_CARD_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extCtl <= `SCP_EXT_RESET;
    end else if (commit && wrLane && wrSel == SEL_EXT) begin
      extCtl <= wrData & `SCP_EXT_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auxDir <= `SCP_AUXDIR_RESET;
    end else if (commit && wrLane && wrSel == SEL_AUX) begin
      auxDir <= wrData & `SCP_AUXDIR_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      modeReg <= `SCP_MODE_RESET;
    end else if (commit && wrLane && wrSel == SEL_MODE) begin
      modeReg <= wrData & `SCP_MODE_MASK;
    end
  end

  // pin synchronisers and clock-rise capture
  assign pinRaw = {extDataIn, aux8In, aux4In, cardDataIn};
  assign capEn  = {extClk && !extClkPrev, 2'b00, cardClk && !cardClkPrev};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      scp_pin_sync u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pinAsync  (pinRaw[g]),
        .captureEn (capEn[g]),
        .pinLevel  (syncVal[g]),
        .captured  (capVal[g])
      );
    end
  endgenerate

  // card clock source sampled into the clock domain
  scp_pin_sync u_etu_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pinAsync  (etuClk),
    .captureEn (1'b0),
    .pinLevel  (etuLevel),
    .captured  ()
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cardClkPrev <= 1'b0;
      extClkPrev <= 1'b0;
    end else begin
      cardClkPrev <= cardClk;
      extClkPrev <= extClk;
    end
  end

  always_comb begin
    cardRead = cardCtl & `SCP_CARD_MASK;
    cardRead[`SCP_CARD_DATA] = iSync ? capVal[0] : syncVal[0];
    cardRead[`SCP_CARD_AUX8] = auxDir[`SCP_AUX8_DIR] ? syncVal[2]
                                                     : cardCtl[`SCP_CARD_AUX8];
    cardRead[`SCP_CARD_AUX4] = auxDir[`SCP_AUX4_DIR] ? syncVal[1]
                                                     : cardCtl[`SCP_CARD_AUX4];
    extRead = extCtl & `SCP_EXT_MASK;
    if (eSync) begin
      extRead[`SCP_EXT_DATA] = capVal[3];
    end else if (extCtl[`SCP_EXT_DIR]) begin
      extRead[`SCP_EXT_DATA] = syncVal[3];
    end
  end

  always_comb begin
    case (rdSel)
      SEL_CARD: rdByte = cardRead;
      SEL_EXT:  rdByte = extRead;
      SEL_AUX:  rdByte = auxDir;
      SEL_MODE: rdByte = modeReg;
      default:  rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SCP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rdByte};
        s_axi_rresp <= (rdSel == SEL_NONE) ? `SCP_RESP_SLVERR
                                           : `SCP_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    if (iSync) begin
      next_cardRst = cardCtl[`SCP_CARD_RST];
    end else begin
      next_cardRst = !cardCtl[`SCP_CARD_RST] && (!autoSeq || seqRstRelease);
    end
  end

  always_comb begin
    if (bypass || cardCtl[`SCP_CARD_OFF]) begin
      next_cardClk = cardCtl[`SCP_CARD_LVL];
    end else begin
      next_cardClk = etuLevel;
    end
  end

  always_comb begin
    if (bypass || extCtl[`SCP_EXT_OFF]) begin
      next_extClk = extCtl[`SCP_EXT_LVL];
    end else begin
      next_extClk = etuLevel;
    end
  end

  // pin drivers, card data routed to bits when direct, external data when extDirect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cardRst <= 1'b1;
      cardClk <= 1'b0;
      cardDataOut <= 1'b0;
      cardDataOeN <= 1'b1;
    end else begin
      cardRst <= next_cardRst;
      cardClk <= next_cardClk;
      cardDataOut <= direct ? cardCtl[`SCP_CARD_DATA] : uartTxData;
      cardDataOeN <= direct ? cardCtl[`SCP_CARD_DIR] : !uartTxEn;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux4Out <= 1'b0;
      aux4OeN <= 1'b1;
      aux8Out <= 1'b0;
      aux8OeN <= 1'b1;
    end else begin
      aux4Out <= cardCtl[`SCP_CARD_AUX4];
      aux4OeN <= auxDir[`SCP_AUX4_DIR];
      aux8Out <= cardCtl[`SCP_CARD_AUX8];
      aux8OeN <= auxDir[`SCP_AUX8_DIR];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extDataOut <= 1'b0;
      extDataOeN <= 1'b1;
      extClk <= 1'b0;
    end else begin
      extDataOut <= extDirect ? extCtl[`SCP_EXT_DATA] : extUartTxData;
      extDataOeN <= extDirect ? extCtl[`SCP_EXT_DIR] : !extUartTxEn;
      extClk <= next_extClk;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_rst_inv;
    !iSync && !autoSeq |=> cardRst == !$past(cardCtl[`SCP_CARD_RST]);
  endproperty
  a_rst_inv: assert property (p_rst_inv)
    else $error("reset line not inverted");

  property p_rst_auto;
    autoSeq && !iSync && cardCtl[`SCP_CARD_RST] |=> !cardRst;
  endproperty
  a_rst_auto: assert property (p_rst_auto)
    else $error("reset bit ignored in auto mode");

  property p_rst_sync;
    iSync |=> cardRst == $past(cardCtl[`SCP_CARD_RST]);
  endproperty
  a_rst_sync: assert property (p_rst_sync)
    else $error("sync reset not direct");

  property p_cap_card;
    capEn[0] |=> capVal[0] == $past(syncVal[0]);
  endproperty
  a_cap_card: assert property (p_cap_card)
    else $error("card data not captured");

  property p_dir_card;
    direct |=> cardDataOeN == $past(cardCtl[`SCP_CARD_DIR]);
  endproperty
  a_dir_card: assert property (p_dir_card)
    else $error("card direction wrong");

  property p_aux_out;
    !auxDir[`SCP_AUX8_DIR] |=> !aux8OeN &&
      aux8Out == $past(cardCtl[`SCP_CARD_AUX8]);
  endproperty
  a_aux_out: assert property (p_aux_out)
    else $error("aux8 output not driven");

  property p_aux_in;
    auxDir[`SCP_AUX4_DIR] |=> aux4OeN;
  endproperty
  a_aux_in: assert property (p_aux_in)
    else $error("aux4 driven as input");

  property p_clk_stop;
    !bypass && cardCtl[`SCP_CARD_OFF] |=>
      cardClk == $past(cardCtl[`SCP_CARD_LVL]);
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("stopped clock level wrong");

  property p_clk_byp;
    bypass ##1 bypass |-> cardClk == $past(cardCtl[`SCP_CARD_LVL]);
  endproperty
  a_clk_byp: assert property (p_clk_byp)
    else $error("bypass clock level wrong");

  property p_clk_run;
    !bypass && !cardCtl[`SCP_CARD_OFF] |=> cardClk == $past(etuLevel);
  endproperty
  a_clk_run: assert property (p_clk_run)
    else $error("card clock not running");

  property p_ext_dir;
    extDirect |=> extDataOeN == $past(extCtl[`SCP_EXT_DIR]);
  endproperty
  a_ext_dir: assert property (p_ext_dir)
    else $error("external direction wrong");

  property p_ext_clk;
    !bypass && !extCtl[`SCP_EXT_OFF] |=> extClk == $past(etuLevel);
  endproperty
  a_ext_clk: assert property (p_ext_clk)
    else $error("external clock not running");

  property p_cap_ext;
    capEn[3] |=> capVal[3] == $past(syncVal[3]);
  endproperty
  a_cap_ext: assert property (p_cap_ext)
    else $error("external data not captured");

  property p_wr_resp;
    commit |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");

  c_sync_cap: cover property (iSync && capEn[0]);
  c_bypass: cover property (bypass && $changed(cardClk));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : scp_pin_control
`default_nettype wire

// [tb/scp_card_model.sv]
// card contact model that resolves each shared line level
`timescale 1ns/100ps
`default_nettype none
module scp_card_model (
  input  wire logic cardVal,
  input  wire logic aux4Val,
  input  wire logic aux8Val,
  input  wire logic extVal,
  input  wire logic cardDataOut,
  input  wire logic cardDataOeN,
  input  wire logic aux4Out,
  input  wire logic aux4OeN,
  input  wire logic aux8Out,
  input  wire logic aux8OeN,
  input  wire logic extDataOut,
  input  wire logic extDataOeN,
  output var  logic cardDataIn,
  output var  logic aux4In,
  output var  logic aux8In,
  output var  logic extDataIn
);
  // block drives only while enable low
  always_comb begin
    cardDataIn = cardDataOeN ? cardVal : cardDataOut;
    aux4In     = aux4OeN ? aux4Val : aux4Out;
    aux8In     = aux8OeN ? aux8Val : aux8Out;
    extDataIn  = extDataOeN ? extVal : extDataOut;
  end
endmodule : scp_card_model
`default_nettype wire

// [tb/scp_pin_control_tb_top.sv]
// self-checking bench of the pin control block
`timescale 1ns/100ps
`default_nettype none
`include "scp_regs.svh"
module scp_pin_control_tb_top;
  import scp_pkg::*;
  logic ref_clk, rst, etuClk, seqRstRelease;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [17:0] awAddr, arAddr;
  logic [1:0] bResp, rResp;
  logic [3:0] wStrb;
  scp_word_type wData, rData;
  logic txData, txEn, cardRst, cardClk, extClk;
  logic cardVal, aux4Val, aux8Val, extVal;
  logic cardDataIn, cardDataOut, cardDataOeN, aux4In, aux4Out, aux4OeN;
  logic aux8In, aux8Out, aux8OeN, extDataIn, extDataOut, extDataOeN;
  int mismatches, compares;
  localparam logic [1:0] OK = `SCP_RESP_OKAY;
  scp_pin_control dut (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .etuClk(etuClk),
    .seqRstRelease(seqRstRelease), .uartTxData(txData), .uartTxEn(txEn),
    .extUartTxData(txData), .extUartTxEn(txEn), .cardRst(cardRst),
    .cardClk(cardClk), .cardDataIn(cardDataIn), .cardDataOut(cardDataOut),
    .cardDataOeN(cardDataOeN), .aux4In(aux4In), .aux4Out(aux4Out),
    .aux4OeN(aux4OeN), .aux8In(aux8In), .aux8Out(aux8Out),
    .aux8OeN(aux8OeN), .extDataIn(extDataIn), .extDataOut(extDataOut),
    .extDataOeN(extDataOeN), .extClk(extClk));
  scp_card_model card (.cardVal(cardVal), .aux4Val(aux4Val),
    .aux8Val(aux8Val), .extVal(extVal), .cardDataOut(cardDataOut),
    .cardDataOeN(cardDataOeN), .aux4Out(aux4Out), .aux4OeN(aux4OeN),
    .aux8Out(aux8Out), .aux8OeN(aux8OeN), .extDataOut(extDataOut),
    .extDataOeN(extDataOeN), .cardDataIn(cardDataIn), .aux4In(aux4In),
    .aux8In(aux8In), .extDataIn(extDataIn));
  always #2 ref_clk = ~ref_clk;
  always #62.5 etuClk = ~etuClk;
  task automatic fail(input string msg);
    mismatches++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail
  task automatic checkWord(input scp_word_type got, input scp_word_type exp);
    compares++;
    if (got !== exp) fail($sformatf("word %h, expected %h", got, exp));
  endtask : checkWord
  task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("response %h, expected %h", got, exp));
  endtask : checkResp
  task automatic checkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail($sformatf("pin %b, expected %b", got, exp));
  endtask : checkBit
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick
  task automatic wrReg(input logic [15:0] idx, input logic [7:0] val,
                       input logic [1:0] expResp);
    logic [1:0] resp;
    resp = 2'h3;
    awAddr <= {idx, 2'b00};
    wData <= {24'h0, val};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid === 1'b1) resp = bResp;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    checkResp(resp, expResp);
    tick(1);
  endtask : wrReg
  task automatic rdReg(input logic [15:0] idx, input scp_word_type exp,
                       input logic [1:0] expResp);
    arAddr <= {idx, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    checkWord(rData, exp);
    checkResp(rResp, expResp);
    tick(1);
  endtask : rdReg
  function automatic logic [15:0] idxOf(input int i);
    return i ? `SCP_IDX_EXT : `SCP_IDX_CARD;
  endfunction : idxOf
  function automatic logic clkOf(input int i);
    return i ? extClk : cardClk;
  endfunction : clkOf
  function automatic logic oeNOf(input int i);
    return i ? extDataOeN : cardDataOeN;
  endfunction : oeNOf
  task automatic setVal(input int i, input logic v);
    if (i) extVal <= v;
    else cardVal <= v;
  endtask : setVal
  task automatic testReset;
    rdReg(`SCP_IDX_CARD, 32'h39, OK);
    rdReg(`SCP_IDX_EXT, 32'h00, OK);
    rdReg(`SCP_IDX_AUXDIR, 32'h0C, OK);
    rdReg(16'h0010, 32'h00, `SCP_RESP_SLVERR);
    checkBit(cardRst, 1'b1);
    checkBit(aux4OeN, 1'b1);
    checkBit(aux8OeN, 1'b1);
    checkBit(cardDataOeN, 1'b1);
  endtask : testReset
  task automatic testCardReset;
    wrReg(`SCP_IDX_CARD, 8'h91, OK);
    tick(2);
    checkBit(cardRst, 1'b0);
    wrReg(`SCP_IDX_CARD, 8'h11, OK);
    tick(2);
    checkBit(cardRst, 1'b1);
    wrReg(`SCP_IDX_MODE, 8'h02, OK);
    tick(2);
    checkBit(cardRst, 1'b0);
    seqRstRelease <= 1'b1;
    tick(2);
    checkBit(cardRst, 1'b1);
    wrReg(`SCP_IDX_CARD, 8'h91, OK);
    tick(2);
    checkBit(cardRst, 1'b0);
    wrReg(`SCP_IDX_MODE, 8'h04, OK);
    tick(2);
    checkBit(cardRst, 1'b1);
    wrReg(`SCP_IDX_CARD, 8'h11, OK);
    tick(2);
    checkBit(cardRst, 1'b0);
    wrReg(`SCP_IDX_MODE, 8'h00, OK);
  endtask : testCardReset
  task automatic testClocks;
    for (int i = 0; i < 2; i++) begin
      wrReg(idxOf(i), 8'h13, OK);
      tick(2);
      checkBit(clkOf(i), 1'b1);
      wrReg(idxOf(i), 8'h11, OK);
      tick(2);
      checkBit(clkOf(i), 1'b0);
      wrReg(idxOf(i), 8'h10, OK);
      @(posedge etuClk);
      tick(6);
      checkBit(clkOf(i), 1'b1);
      @(negedge etuClk);
      tick(6);
      checkBit(clkOf(i), 1'b0);
      wrReg(`SCP_IDX_MODE, 8'h01, OK);
      wrReg(idxOf(i), 8'h12, OK);
      @(negedge etuClk);
      tick(6);
      checkBit(clkOf(i), 1'b1);
      wrReg(idxOf(i), 8'h10, OK);
      @(posedge etuClk);
      tick(6);
      checkBit(clkOf(i), 1'b0);
      wrReg(`SCP_IDX_MODE, 8'h00, OK);
    end
  endtask : testClocks
  task automatic testData;
    for (int i = 0; i < 2; i++) begin
      wrReg(`SCP_IDX_MODE, 8'h01, OK);
      wrReg(idxOf(i), 8'h20, OK);
      tick(2);
      checkBit(oeNOf(i), 1'b0);
      checkBit(i ? extDataOut : cardDataOut, 1'b1);
      tick(4);
      rdReg(idxOf(i), i ? 32'h20 : 32'h28, OK);
      wrReg(idxOf(i), 8'h10, OK);
      setVal(i, 1'b1);
      tick(6);
      rdReg(idxOf(i), i ? 32'h30 : 32'h38, OK);
      setVal(i, 1'b0);
      tick(6);
      rdReg(idxOf(i), i ? 32'h10 : 32'h18, OK);
      wrReg(`SCP_IDX_MODE, 8'h00, OK);
      wrReg(idxOf(i), 8'h00, OK);
      tick(2);
      checkBit(oeNOf(i), 1'b1);
    end
    {txData, txEn} <= 2'h3;
    tick(2);
    checkBit(cardDataOeN, 1'b0);
    checkBit(cardDataOut, 1'b1);
    checkBit(extDataOeN, 1'b0);
    {txData, txEn} <= 2'h0;
  endtask : testData
  task automatic testAux;
    wrReg(`SCP_IDX_AUXDIR, 8'h00, OK);
    wrReg(`SCP_IDX_CARD, 8'h1D, OK);
    tick(2);
    checkBit(aux4OeN, 1'b0);
    checkBit(aux4Out, 1'b1);
    checkBit(aux8Out, 1'b1);
    rdReg(`SCP_IDX_CARD, 32'h1D, OK);
    wrReg(`SCP_IDX_AUXDIR, 8'h0C, OK);
    wrReg(`SCP_IDX_CARD, 8'h15, OK);
    tick(6);
    checkBit(aux8OeN, 1'b1);
    checkBit(aux4OeN, 1'b1);
    rdReg(`SCP_IDX_CARD, 32'h19, OK);
    wrReg(`SCP_IDX_AUXDIR, 8'h00, OK);
    rdReg(`SCP_IDX_CARD, 32'h15, OK);
    wrReg(`SCP_IDX_AUXDIR, 8'h0C, OK);
  endtask : testAux
  task automatic testSync;
    for (int i = 0; i < 2; i++) begin
      wrReg(`SCP_IDX_MODE, i ? 8'h08 : 8'h04, OK);
      wrReg(idxOf(i), 8'h10, OK);
      setVal(i, 1'b1);
      @(posedge etuClk);
      @(posedge etuClk);
      tick(15);
      setVal(i, 1'b0);
      rdReg(idxOf(i), i ? 32'h30 : 32'h38, OK);
      @(posedge etuClk);
      tick(10);
      rdReg(idxOf(i), i ? 32'h10 : 32'h18, OK);
    end
    wrReg(`SCP_IDX_MODE, 8'h00, OK);
  endtask : testSync
  task automatic testUnused;
    extVal <= 1'b1;
    wrReg(`SCP_IDX_EXT, 8'hFF, OK);
    tick(6);
    rdReg(`SCP_IDX_EXT, 32'h33, OK);
    wrReg(`SCP_IDX_CARD, 8'h51, OK);
    rdReg(`SCP_IDX_CARD, 32'h19, OK);
    wStrb <= 4'h0;
    wrReg(`SCP_IDX_CARD, 8'h00, OK);
    wStrb <= 4'h1;
    rdReg(`SCP_IDX_CARD, 32'h19, OK);
    wrReg(`SCP_IDX_AUXDIR, 8'hFF, OK);
    rdReg(`SCP_IDX_AUXDIR, 32'h0C, OK);
    wrReg(16'h0010, 8'h55, `SCP_RESP_SLVERR);
  endtask : testUnused
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    ref_clk = 1'b0;
    etuClk = 1'b0;
    rst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    awAddr = 18'h0;
    arAddr = 18'h0;
    wData = 32'h0;
    wStrb = 4'h1;
    {seqRstRelease, txData, txEn} = 3'h0;
    {cardVal, aux4Val, aux8Val, extVal} = 4'hA;
    mismatches = 0;
    compares = 0;
    tick(12);
    rst <= 1'b0;
    tick(2);
    testReset();
    testCardReset();
    testClocks();
    testData();
    testAux();
    testSync();
    testUnused();
    summarize();
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule : scp_pin_control_tb_top
`default_nettype wire
